// *** inc/aisc_defines.svh ***
// Constants of the analog input scaling curve block: offsets, resets and timing
`ifndef AISC_DEFINES_SVH
`define AISC_DEFINES_SVH

// Global registers (byte addresses)
`define AISC_OFF_MASTER 12'h000
`define AISC_OFF_STAT 12'h004
`define AISC_OFF_MASK 12'h008
`define AISC_OFF_OOR 12'h00C

// Per-curve window: curve c sits at (c + 1) * 0x100, register offsets inside it
`define AISC_OFF_CFG 8'h00
`define AISC_OFF_TAU 8'h04
`define AISC_OFF_UPD 8'h08
`define AISC_OFF_MIN 8'h0C
`define AISC_OFF_MAX 8'h10
`define AISC_OFF_IN 8'h14
`define AISC_OFF_OUT 8'h18
`define AISC_OFF_PTEN 8'h1C
`define AISC_OFF_PT 8'h40
`define AISC_PT_STRIDE 8'h08

// Field widths
`define AISC_CFG_W 10
`define AISC_TIME_W 20
`define AISC_FRAC 16

// Timing: one step of the filter and update settings
`define AISC_CLK_NS 25
`define AISC_STEP_NS 5000000
`define AISC_TAU_DEF_MS 1000
`define AISC_UPD_DEF_MS 150
`define AISC_STEP_MS 5

// Reset values
`define AISC_RST_TAU (`AISC_TAU_DEF_MS / `AISC_STEP_MS)
`define AISC_RST_UPD (`AISC_UPD_DEF_MS / `AISC_STEP_MS)
`define AISC_RST_PT1_IN (32'h1 << `AISC_FRAC)

`endif

// *** inc/aisc_pkg.sv ***
// Types shared by the analog input scaling curve block
package aisc_pkg;

	// Output rounding forms
	typedef enum logic [1:0] {
		RND_FLOAT = 2'b00,
		RND_FLOOR = 2'b01,
		RND_CEIL = 2'b10,
		RND_NEAR = 2'b11
	} aisc_rnd_t;

	// Per-curve configuration word, bit 0 upward: enable, filter, supervision, rounding, source
	typedef struct packed {
		logic [4:0] src;
		aisc_rnd_t rnd;
		logic oor_en;
		logic filt_en;
		logic curve_en;
	} aisc_cfg_t;

	// One sampled measurement from an input card
	typedef struct packed {
		logic valid;
		logic signed [31:0] value;
	} aisc_meas_t;

	// Processing engine states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_LOAD = 4'b0001,
		ST_FILT = 4'b0010,
		ST_FDIV = 4'b0011,
		ST_CHK = 4'b0100,
		ST_SEG = 4'b0101,
		ST_IDIV = 4'b0110,
		ST_ROUND = 4'b0111
	} aisc_state_t;

endpackage : aisc_pkg

// *** src/aisc_top.sv ***
// Analog input scaling curves: APB registers, filter, supervision and curve mapping
//
// Operation
// - Per-channel master enable, off after reset; off means no scaling.
// - Per-curve enable, off after reset; off means no processing and no output.
// - Each curve selects one measurement source; default is source zero.
// - Optional first-order running-average filter replaces the raw input; off by default.
// - Filter time constant in 5 ms steps, default 1 s, used only when filtering.
// - Out-of-range supervision option, off by default; flag driven only when on.
// - Flag raised while input is below the minimum limit, default 0.
// - Flag raised while input is above the maximum limit.
// - Out-of-range flags leave the block as binary signals.
// - Received input value of each curve is readable.
// - Present scaled output of each curve is readable.
// - Lost input signal holds the last valid value, never drops to minimum.
// - Input refreshed once per update cycle, 5 ms steps, default 150 ms.
// - Output form: fixed point, floor, ceiling or nearest; fixed point default.
// - Two base points pair input and output; default inputs 0 and 1.
// - Points three to twenty each have their own enable.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "aisc_defines.svh"

module aisc_top #(
	parameter int NCURVE = 10,
	parameter int NPT = 20,
	parameter int NUM_SRC = 16,
	parameter int TICK_CYC = `AISC_STEP_NS / `AISC_CLK_NS
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic SYS_RST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Measurements from input cards
	input wire aisc_pkg::aisc_meas_t [NUM_SRC-1:0] MEAS_IN,
	// Flags and interrupt
	output logic [NCURVE-1:0] SCALING_CURVE_OUT_OF_RANGE,
	output logic IRQ
);
	import aisc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Storage
	logic [NCURVE-1:0] master_r;
	logic [NCURVE-1:0] stat_r;
	logic [NCURVE-1:0] mask_r;
	aisc_cfg_t cfg_r [NCURVE];
	logic [`AISC_TIME_W-1:0] tau_r [NCURVE];
	logic [`AISC_TIME_W-1:0] upd_r [NCURVE];
	logic signed [31:0] min_r [NCURVE];
	logic signed [31:0] max_r [NCURVE];
	logic [NPT-1:0] pten_r [NCURVE];
	logic signed [31:0] pin_r [NCURVE][NPT];
	logic signed [31:0] pout_r [NCURVE][NPT];
	logic signed [31:0] in_r [NCURVE];
	logic signed [31:0] out_r [NCURVE];
	logic signed [31:0] filt_r [NCURVE];
	logic [NCURVE-1:0] finit_r;
	logic [NCURVE-1:0] oor_r;
	logic [NCURVE-1:0] oor_d_r;
	logic [`AISC_TIME_W-1:0] cnt_r [NCURVE];
	logic [NCURVE-1:0] pend_r;
	logic [31:0] rdata_r;
	logic [23:0] tick_cnt_r;
	logic tick;

	// Engine state
	aisc_state_t st_r;
	logic [3:0] ci_r;
	logic [4:0] pi_r;
	logic [4:0] prv_r;
	logic prv_ok_r;
	logic signed [31:0] x_r;
	logic signed [31:0] res_r;
	logic [63:0] div_num_r;
	logic [32:0] div_rem_r;
	logic [31:0] div_den_r;
	logic div_neg_r;
	logic [5:0] div_cnt_r;
	logic [NCURVE-1:0] pend_clr;

	////////////////////////////////////////////////////////////////////////////////
	// APB decode
	wire logic [3:0] page = PADDR[11:8];
	wire logic [7:0] off = PADDR[7:0];
	wire logic [3:0] pc = page - 4'h1;
	wire logic glb_hit = (page == 4'h0) && (off < 8'h10);
	wire logic cur_hit = (page != 4'h0) && (32'(page) <= NCURVE);
	wire logic [7:0] pt_off = off - `AISC_OFF_PT;
	wire logic [4:0] pidx = pt_off[7:3];
	wire logic pt_hit = (off >= `AISC_OFF_PT) && (32'(pidx) < NPT) && (pt_off[1:0] == 2'b00);
	wire logic reg_hit = (off <= `AISC_OFF_PTEN) && (off[1:0] == 2'b00);
	wire logic map_ok = (glb_hit && off[1:0] == 2'b00) || (cur_hit && (reg_hit || pt_hit));
	wire logic setup = PSEL && !PENABLE;
	wire logic wr = PSEL && PENABLE && PWRITE && map_ok;
	wire logic wr_cur = wr && cur_hit && reg_hit;
	wire logic wr_pt = wr && cur_hit && pt_hit;

	// Zero-wait slave; read data was fetched during setup
	assign PREADY = PSEL && PENABLE;
	assign PSLVERR = PSEL && PENABLE && !map_ok;
	assign PRDATA = rdata_r;

	// Read multiplexer
	logic [31:0] rmux;
	always_comb
	begin
		rmux = 32'h00000000;
		if (glb_hit)
		begin
			case (PADDR)
				`AISC_OFF_MASTER: rmux = 32'(master_r);
				`AISC_OFF_STAT: rmux = 32'(stat_r);
				`AISC_OFF_MASK: rmux = 32'(mask_r);
				`AISC_OFF_OOR: rmux = 32'(oor_r);
				default: rmux = 32'h00000000;
			endcase
		end
		else if (cur_hit && pt_hit)
			rmux = pt_off[2] ? pout_r[pc][pidx] : pin_r[pc][pidx];
		else if (cur_hit)
		begin
			case (off)
				`AISC_OFF_CFG: rmux = 32'(cfg_r[pc]);
				`AISC_OFF_TAU: rmux = 32'(tau_r[pc]);
				`AISC_OFF_UPD: rmux = 32'(upd_r[pc]);
				`AISC_OFF_MIN: rmux = min_r[pc];
				`AISC_OFF_MAX: rmux = max_r[pc];
				`AISC_OFF_IN: rmux = in_r[pc];
				`AISC_OFF_OUT: rmux = out_r[pc];
				`AISC_OFF_PTEN: rmux = 32'(pten_r[pc]);
				default: rmux = 32'h00000000;
			endcase
		end
	end

	// Capture read data at setup so PRDATA comes from a flop
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
			rdata_r <= 32'h00000000;
		else if (setup)
			rdata_r <= rmux;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Global registers and interrupt
	wire logic [NCURVE-1:0] oor_rise = oor_r & ~oor_d_r;
	wire logic [NCURVE-1:0] stat_clr = (wr && PADDR == `AISC_OFF_STAT) ? PWDATA[NCURVE-1:0] : '0;
	// A new rising flag wins over a clear in the same cycle
	wire logic [NCURVE-1:0] stat_nxt = (stat_r & ~stat_clr) | oor_rise;

	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			master_r <= '0;
			mask_r <= '0;
			stat_r <= '0;
			oor_d_r <= '0;
		end
		else
		begin
			stat_r <= stat_nxt;
			oor_d_r <= oor_r;
			if (wr && PADDR == `AISC_OFF_MASTER)
				master_r <= PWDATA[NCURVE-1:0];
			if (wr && PADDR == `AISC_OFF_MASK)
				mask_r <= PWDATA[NCURVE-1:0];
		end
	end

	assign IRQ = |(stat_r & mask_r);
	assign SCALING_CURVE_OUT_OF_RANGE = oor_r;

	////////////////////////////////////////////////////////////////////////////////
	// Per-curve settings and curve points
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			for (int c = 0; c < NCURVE; c++)
			begin
				cfg_r[c] <= '0;
				tau_r[c] <= `AISC_TIME_W'(`AISC_RST_TAU);
				upd_r[c] <= `AISC_TIME_W'(`AISC_RST_UPD);
				min_r[c] <= 32'sh00000000;
				max_r[c] <= 32'sh00000000;
				pten_r[c] <= '0;
				for (int p = 0; p < NPT; p++)
				begin
					pin_r[c][p] <= (p == 1) ? `AISC_RST_PT1_IN : 32'sh00000000;
					pout_r[c][p] <= 32'sh00000000;
				end
			end
		end
		else
		begin
			if (wr_cur)
			begin
				case (off)
					`AISC_OFF_CFG: cfg_r[pc] <= aisc_cfg_t'(PWDATA[`AISC_CFG_W-1:0]);
					`AISC_OFF_TAU: tau_r[pc] <= PWDATA[`AISC_TIME_W-1:0];
					`AISC_OFF_UPD: upd_r[pc] <= PWDATA[`AISC_TIME_W-1:0];
					`AISC_OFF_MIN: min_r[pc] <= PWDATA;
					`AISC_OFF_MAX: max_r[pc] <= PWDATA;
					`AISC_OFF_PTEN: pten_r[pc] <= PWDATA[NPT-1:0];
					default: ;
				endcase
			end
			if (wr_pt && pt_off[2])
				pout_r[pc][pidx] <= PWDATA;
			else if (wr_pt)
				pin_r[pc][pidx] <= PWDATA;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// 5 ms step and per-curve update cycle
	wire logic [NCURVE-1:0] act;
	for (genvar g = 0; g < NCURVE; g++)
	begin : g_act
		assign act[g] = master_r[g] && cfg_r[g].curve_en;
	end

	assign tick = (tick_cnt_r == 24'(TICK_CYC - 1));

	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
			tick_cnt_r <= 24'h000000;
		else
			tick_cnt_r <= tick ? 24'h000000 : tick_cnt_r + 24'h000001;
	end

	// Update counters; a new request wins over the engine taking the old one
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			pend_r <= '0;
			for (int c = 0; c < NCURVE; c++)
				cnt_r[c] <= '0;
		end
		else
		begin
			for (int c = 0; c < NCURVE; c++)
			begin
				if (!act[c])
				begin
					cnt_r[c] <= '0;
					pend_r[c] <= 1'b0;
				end
				else if (tick && cnt_r[c] + 1'b1 >= upd_r[c])
				begin
					cnt_r[c] <= '0;
					pend_r[c] <= 1'b1;
				end
				else
				begin
					cnt_r[c] <= tick ? cnt_r[c] + 1'b1 : cnt_r[c];
					pend_r[c] <= pend_r[c] & ~pend_clr[c];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shared serial divider and datapath terms
	wire logic [32:0] rem_sh = {div_rem_r[31:0], div_num_r[63]};
	wire logic div_ge = rem_sh >= {1'b0, div_den_r};
	wire logic [63:0] num_nxt = {div_num_r[62:0], div_ge};
	wire logic [32:0] rem_nxt = div_ge ? rem_sh - {1'b0, div_den_r} : rem_sh;
	wire logic signed [31:0] quo = div_neg_r ? -$signed(num_nxt[31:0]) : $signed(num_nxt[31:0]);

	aisc_cfg_t ccfg;
	aisc_meas_t msel;
	assign ccfg = cfg_r[ci_r];
	assign msel = MEAS_IN[ccfg.src[$clog2(NUM_SRC)-1:0]];
	wire logic src_ok = (32'(ccfg.src) < NUM_SRC) && msel.valid;
	// Lost signal keeps the last good sample
	wire logic signed [31:0] raw = src_ok ? msel.value : in_r[ci_r];
	wire logic signed [32:0] fd = 33'(x_r) - 33'(filt_r[ci_r]);
	wire logic [32:0] fd_mag = fd[32] ? -fd : fd;
	wire logic pt_en = (pi_r < 5'd2) || pten_r[ci_r][pi_r];
	wire logic signed [31:0] p_in = pin_r[ci_r][pi_r];
	wire logic signed [31:0] p_out = pout_r[ci_r][pi_r];
	wire logic signed [31:0] v_in = pin_r[ci_r][prv_r];
	wire logic signed [31:0] v_out = pout_r[ci_r][prv_r];
	wire logic signed [32:0] dy = 33'(p_out) - 33'(v_out);
	wire logic [31:0] dy_mag = dy[32] ? 32'(-dy) : dy[31:0];
	wire logic [31:0] dx = 32'(x_r - v_in);
	wire logic [31:0] dxw = 32'(p_in - v_in);
	wire logic last_pt = (32'(pi_r) == NPT - 1);

	// Rounding of the scaled value in its fixed-point form
	localparam logic [31:0] FMASK = (32'h1 << `AISC_FRAC) - 32'h1;
	localparam logic [31:0] FHALF = 32'h1 << (`AISC_FRAC - 1);
	logic [31:0] rounded;
	always_comb
	begin
		case (aisc_rnd_t'(ccfg.rnd))
			RND_FLOOR: rounded = res_r & ~FMASK;
			RND_CEIL: rounded = (res_r + FMASK) & ~FMASK;
			RND_NEAR: rounded = (res_r + FHALF) & ~FMASK;
			default: rounded = res_r;
		endcase
	end

	always_comb
	begin
		pend_clr = '0;
		if (st_r == ST_IDLE && pend_r[ci_r] && act[ci_r])
			pend_clr[ci_r] = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Processing engine: one curve at a time, round robin over pending curves
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			st_r <= ST_IDLE;
			ci_r <= 4'h0;
			pi_r <= 5'h00;
			prv_r <= 5'h00;
			prv_ok_r <= 1'b0;
			x_r <= 32'sh00000000;
			res_r <= 32'sh00000000;
			div_num_r <= 64'h0000000000000000;
			div_rem_r <= 33'h000000000;
			div_den_r <= 32'h00000000;
			div_neg_r <= 1'b0;
			div_cnt_r <= 6'h00;
			finit_r <= '0;
			oor_r <= '0;
			for (int c = 0; c < NCURVE; c++)
			begin
				in_r[c] <= 32'sh00000000;
				out_r[c] <= 32'sh00000000;
				filt_r[c] <= 32'sh00000000;
			end
		end
		else
		begin
			case (st_r)
				ST_IDLE:
				begin
					if (pend_r[ci_r] && act[ci_r])
						st_r <= ST_LOAD;
					else
						ci_r <= (32'(ci_r) == NCURVE - 1) ? 4'h0 : ci_r + 4'h1;
				end
				ST_LOAD:
				begin
					in_r[ci_r] <= raw;
					x_r <= raw;
					if (!ccfg.filt_en)
					begin
						finit_r[ci_r] <= 1'b0;
						st_r <= ST_CHK;
					end
					else if (!finit_r[ci_r])
					begin
						filt_r[ci_r] <= raw;
						finit_r[ci_r] <= 1'b1;
						st_r <= ST_CHK;
					end
					else
						st_r <= ST_FILT;
				end
				ST_FILT:
				begin
					// Step gain is update period over (time constant + update period)
					div_num_r <= 64'(fd_mag) * 64'(upd_r[ci_r]);
					div_den_r <= 32'(tau_r[ci_r]) + 32'(upd_r[ci_r]);
					div_neg_r <= fd[32];
					div_rem_r <= 33'h000000000;
					div_cnt_r <= 6'h00;
					st_r <= ST_FDIV;
				end
				ST_FDIV:
				begin
					div_num_r <= num_nxt;
					div_rem_r <= rem_nxt;
					div_cnt_r <= div_cnt_r + 6'h01;
					if (div_cnt_r == 6'h3F)
					begin
						filt_r[ci_r] <= filt_r[ci_r] + quo;
						x_r <= filt_r[ci_r] + quo;
						st_r <= ST_CHK;
					end
				end
				ST_CHK:
				begin
					oor_r[ci_r] <= ccfg.oor_en && ((x_r < min_r[ci_r]) || (x_r > max_r[ci_r]));
					pi_r <= 5'h00;
					prv_ok_r <= 1'b0;
					st_r <= ST_SEG;
				end
				ST_SEG:
				begin
					// Walk enabled points; assumes their inputs ascend
					if (pt_en && !prv_ok_r && x_r <= p_in)
					begin
						res_r <= p_out; // Below the first point: clamp
						st_r <= ST_ROUND;
					end
					else if (pt_en && prv_ok_r && x_r <= p_in)
					begin
						div_num_r <= 64'(dx) * 64'(dy_mag);
						div_den_r <= dxw;
						div_neg_r <= dy[32];
						div_rem_r <= 33'h000000000;
						div_cnt_r <= 6'h00;
						res_r <= v_out;
						st_r <= ST_IDIV;
					end
					else
					begin
						if (pt_en)
						begin
							prv_r <= pi_r;
							prv_ok_r <= 1'b1;
						end
						if (last_pt)
						begin
							res_r <= pt_en ? p_out : v_out; // Beyond the last point: clamp
							st_r <= ST_ROUND;
						end
						pi_r <= pi_r + 5'h01;
					end
				end
				ST_IDIV:
				begin
					div_num_r <= num_nxt;
					div_rem_r <= rem_nxt;
					div_cnt_r <= div_cnt_r + 6'h01;
					if (div_cnt_r == 6'h3F)
					begin
						res_r <= res_r + quo;
						st_r <= ST_ROUND;
					end
				end
				ST_ROUND:
				begin
					out_r[ci_r] <= rounded;
					ci_r <= (32'(ci_r) == NCURVE - 1) ? 4'h0 : ci_r + 4'h1;
					st_r <= ST_IDLE;
				end
				default: st_r <= ST_IDLE;
			endcase
			// Disabled curves give no output and no flag
			for (int c = 0; c < NCURVE; c++)
			begin
				if (!act[c])
				begin
					out_r[c] <= 32'sh00000000;
					oor_r[c] <= 1'b0;
					finit_r[c] <= 1'b0;
				end
			end
		end
	end

endmodule : aisc_top

// *** sim/aisc_monitor.sv ***
// Port checker of the analog input scaling curve block
`timescale 1ns/1ps
module aisc_monitor #(
	parameter int NCURVE = 10
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic SYS_RST,
	// APB
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Flags
	input wire logic [NCURVE-1:0] SCALING_CURVE_OUT_OF_RANGE,
	input wire logic IRQ
);
	default clocking cb_mon @(posedge MCLK); endclocking
	default disable iff (SYS_RST);
	logic [NCURVE-1:0] mst_r, en_r, oor_r, mask_r, stat_r, flag_r, rise;
	logic setup_r, exp_irq, exp_irq_r, wr;
	////////////////////////////////////////////////////////////
	// Shadow registers rebuilt from bus traffic
	assign wr = PSEL && PENABLE && PWRITE;
	assign rise = SCALING_CURVE_OUT_OF_RANGE & ~flag_r;
	assign exp_irq = |(stat_r & mask_r);
	// Sticky status: a new rise wins over a clear
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			{mst_r, en_r, oor_r, mask_r, stat_r, flag_r} <= '0;
			setup_r <= 1'b0;
			exp_irq_r <= 1'b0;
		end
		else
		begin
			flag_r <= SCALING_CURVE_OUT_OF_RANGE;
			setup_r <= PSEL && !PENABLE;
			exp_irq_r <= exp_irq;
			stat_r <= (stat_r & ~((wr && PADDR == 12'h004) ? PWDATA[NCURVE-1:0] : '0)) | rise;
			if (wr && PADDR == 12'h000)
				mst_r <= PWDATA[NCURVE-1:0];
			if (wr && PADDR == 12'h008)
				mask_r <= PWDATA[NCURVE-1:0];
			for (int c = 0; c < NCURVE; c++)
				if (wr && PADDR == 12'((c + 1) * 256))
				begin
					en_r[c] <= PWDATA[0];
					oor_r[c] <= PWDATA[2];
				end
		end
	end
	////////////////////////////////////////////////////////////
	// Bus timing: no wait states, no ready or error while idle; then reset, flag and interrupt checks
	rdy_zero_wait_a: assert property (PSEL && PENABLE |-> PREADY)
		else $error("ready missing in access phase");
	rdy_idle_a: assert property (!PSEL |-> !PREADY && !PSLVERR)
		else $error("ready or error while idle");
	err_unmapped_a: assert property (PSEL && PENABLE && (PADDR[11:4] inside {[8'h01:8'h0F]}
		|| PADDR >= 12'hB00) |-> PSLVERR && (PWRITE || PRDATA == 32'h0))
		else $error("unmapped access not refused");
	err_global_a: assert property (PSEL && PENABLE && PADDR[11:4] == 8'h00
		&& PADDR[1:0] == 2'b00 |-> !PSLVERR)
		else $error("global register refused");
	rdata_hold_a: assert property ($changed(PRDATA) |-> setup_r)
		else $error("read data moved outside setup");
	rst_quiet_a: assert property ($fell(SYS_RST) |-> !IRQ && PRDATA == 32'h0
		&& SCALING_CURVE_OUT_OF_RANGE == '0)
		else $error("outputs active after reset");
	oor_gated_a: assert property ((rise & ~(mst_r & en_r & oor_r)) == '0)
		else $error("flag rose without supervision");
	irq_level_a: assert property (IRQ == exp_irq || IRQ == exp_irq_r)
		else $error("interrupt level wrong");
endmodule : aisc_monitor

// *** sim/aisc_card_model.sv ***
// Measurement card model feeding sampled values
`timescale 1ns/1ps
module aisc_card_model #(
	parameter int NUM_SRC = 16
) (
	// Clock and samples
	input wire logic clk,
	output wire aisc_pkg::aisc_meas_t [NUM_SRC-1:0] meas
);
	import aisc_pkg::*;
	logic [31:0] val_r [NUM_SRC] = '{default: 32'h0};
	logic [NUM_SRC-1:0] ok_r = '1;
	logic [31:0] junk_r = 32'h0F0F5A5A;
	// A lost signal shows changing junk, never the last value
	always_ff @(posedge clk)
		junk_r <= ~junk_r ^ 32'h00FF00FF;
	for (genvar s = 0; s < NUM_SRC; s++)
	begin : g_src
		assign meas[s] = '{valid: ok_r[s], value: ok_r[s] ? val_r[s] : junk_r};
	end
	// New sample from a card, applied after a clock edge
	task put(input int s, input logic [31:0] v, input logic ok);
		@(posedge clk);
		val_r[s] <= v;
		ok_r[s] <= ok;
	endtask : put
endmodule : aisc_card_model

// *** sim/tb_analog_input_scaling_curves.sv ***
// Testbench of the analog input scaling curve block
`timescale 1ns/1ps
module tb_analog_input_scaling_curves;
	import aisc_pkg::*;
	localparam int NCURVE = 10;
	localparam int NUM_SRC = 16;
	logic MCLK = 1'b0;
	logic SYS_RST = 1'b1;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA;
	logic PREADY;
	logic PSLVERR;
	aisc_meas_t [NUM_SRC-1:0] MEAS_IN;
	logic [NCURVE-1:0] SCALING_CURVE_OUT_OF_RANGE;
	logic IRQ;
	int fail_count = 0;
	int total_checks = 0;
	int cyc = 0;
	logic [31:0] rd_v;
	logic err_v;
	always #12.5 MCLK = ~MCLK;
	////////////////////////////////////////////////////////////
	// Block and card model; short step keeps update cycles brief
	aisc_top #(.NCURVE(NCURVE), .NPT(20), .NUM_SRC(NUM_SRC), .TICK_CYC(4)) u_aisc_top (
		.MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.MEAS_IN(MEAS_IN), .SCALING_CURVE_OUT_OF_RANGE(SCALING_CURVE_OUT_OF_RANGE), .IRQ(IRQ));
	aisc_card_model #(.NUM_SRC(NUM_SRC)) u_aisc_card_model (.clk(MCLK), .meas(MEAS_IN));
	////////////////////////////////////////////////////////////
	// Shared tasks
	task report_and_stop();
		if (fail_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
			fail_count++;
		end
	endtask : chk
	// One APB transfer; held until ready is seen at a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge MCLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		do @(posedge MCLK); while (PREADY !== 1'b1);
		rd_v = PRDATA;
		err_v = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	task rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd_v, exp);
	endtask : rdc
	task wt(input int n);
		repeat (n) @(posedge MCLK);
	endtask : wt
	////////////////////////////////////////////////////////////
	// Scenarios
	task t_reset();
		logic [11:0] adr [7] = '{12'h000, 12'h100, 12'h104, 12'h108, 12'h10C, 12'h11C, 12'h148};
		logic [31:0] val [7] = '{32'h0, 32'h0, 32'h000000C8, 32'h0000001E, 32'h0, 32'h0,
			32'h00010000};
		for (int i = 0; i < 7; i++)
			rdc(adr[i], val[i]);
		apb(1'b0, 12'h030, 32'h0);
		chk({31'h0, err_v}, 32'h1);
		apb(1'b1, 12'h118, 32'h12345678);
		rdc(12'h118, 32'h0);
	endtask : t_reset
	task t_curve();
		u_aisc_card_model.put(3, 32'h00018000, 1'b1);
		apb(1'b1, 12'h108, 32'h1);
		apb(1'b1, 12'h148, 32'h00040000);
		apb(1'b1, 12'h14C, 32'h000A0000);
		apb(1'b1, 12'h100, 32'h61);
		wt(300);
		rdc(12'h118, 32'h0);
		apb(1'b1, 12'h000, 32'h1);
		wt(300);
		rdc(12'h114, 32'h00018000);
		rdc(12'h118, 32'h0003C000);
	endtask : t_curve
	task t_round();
		logic [31:0] exp [4] = '{32'h0003C000, 32'h00030000, 32'h00040000, 32'h00040000};
		for (int r = 1; r < 4; r++)
		begin
			apb(1'b1, 12'h100, 32'h61 | (r << 3));
			wt(300);
			rdc(12'h118, exp[r]);
		end
		apb(1'b1, 12'h100, 32'h60);
		wt(300);
		rdc(12'h118, 32'h0);
	endtask : t_round
	task t_points();
		u_aisc_card_model.put(3, 32'h00060000, 1'b1);
		apb(1'b1, 12'h150, 32'h00080000);
		apb(1'b1, 12'h154, 32'h001E0000);
		apb(1'b1, 12'h11C, 32'h4);
		apb(1'b1, 12'h100, 32'h61);
		wt(300);
		rdc(12'h118, 32'h00140000);
		apb(1'b1, 12'h11C, 32'h0);
	endtask : t_points
	task t_oor();
		apb(1'b1, 12'h10C, 32'h00010000);
		apb(1'b1, 12'h110, 32'h00020000);
		u_aisc_card_model.put(3, 32'h00030000, 1'b1);
		wt(300);
		rdc(12'h00C, 32'h0);
		apb(1'b1, 12'h100, 32'h65);
		wt(300);
		chk({31'h0, SCALING_CURVE_OUT_OF_RANGE[0]}, 32'h1);
		rdc(12'h004, 32'h1);
		chk({31'h0, IRQ}, 32'h0);
		apb(1'b1, 12'h008, 32'h1);
		wt(1);
		chk({31'h0, IRQ}, 32'h1);
		apb(1'b1, 12'h004, 32'h1);
		wt(1);
		chk({31'h0, IRQ}, 32'h0);
		u_aisc_card_model.put(3, 32'h00018000, 1'b1);
		wt(300);
		chk({22'h0, SCALING_CURVE_OUT_OF_RANGE}, 32'h0);
		u_aisc_card_model.put(3, 32'h00008000, 1'b1);
		wt(300);
		rdc(12'h00C, 32'h1);
		chk({31'h0, IRQ}, 32'h1);
		apb(1'b1, 12'h004, 32'h1);
	endtask : t_oor
	task t_loss_filter();
		u_aisc_card_model.put(3, 32'h00070000, 1'b0);
		wt(300);
		rdc(12'h114, 32'h00008000);
		u_aisc_card_model.put(3, 32'h00008000, 1'b1);
		apb(1'b1, 12'h104, 32'h000FFFFF);
		apb(1'b1, 12'h100, 32'h6B);
		wt(300);
		rdc(12'h118, 32'h00010000);
		u_aisc_card_model.put(3, 32'h00030000, 1'b1);
		wt(300);
		rdc(12'h114, 32'h00030000);
		rdc(12'h118, 32'h00010000);
	endtask : t_loss_filter
	// Default period restarts on enable; nearest differs from ceiling here
	task t_period();
		apb(1'b1, 12'h100, 32'h60);
		apb(1'b1, 12'h108, 32'h1E);
		u_aisc_card_model.put(3, 32'h00014000, 1'b1);
		apb(1'b1, 12'h100, 32'h79);
		wt(100);
		rdc(12'h114, 32'h00030000);
		wt(200);
		rdc(12'h114, 32'h00014000);
		rdc(12'h118, 32'h00030000);
	endtask : t_period
	////////////////////////////////////////////////////////////
	// Hang guard and main sequence
	always @(posedge MCLK)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			report_and_stop();
		end
	end
	initial
	begin
		wt(10);
		SYS_RST <= 1'b0;
		t_reset();
		t_curve();
		t_round();
		t_points();
		t_oor();
		t_loss_filter();
		t_period();
		report_and_stop();
	end
endmodule : tb_analog_input_scaling_curves

bind aisc_top aisc_monitor #(.NCURVE(NCURVE)) u_aisc_monitor (
	.MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.SCALING_CURVE_OUT_OF_RANGE(SCALING_CURVE_OUT_OF_RANGE), .IRQ(IRQ));
